// [ssr_consts.vh]
// Constants for the clocked synchronous serial unit: register map, field layout,
// reset values and serial clock timing.
// Assumes inclusion by bare name from the design file.
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH

// Register word addresses.
`define SSR_ADDR_CTRL   2'h0
`define SSR_ADDR_STATUS 2'h1
`define SSR_ADDR_RXBUF  2'h2
`define SSR_ADDR_TXBUF  2'h3

// Control register fields.
`define SSR_CTRL_TXON   0
`define SSR_CTRL_RXON   1
`define SSR_CTRL_EMPTY_IEN 2
`define SSR_CTRL_RX_IEN    3
`define SSR_CTRL_DONE_IEN  4
`define SSR_CTRL_CLKINT 5
`define SSR_CTRL_RST    6'h00

// Status register fields.
`define SSR_ST_TXEMPTY  0
`define SSR_ST_RXFULL   1
`define SSR_ST_OVERRUN  2
`define SSR_ST_FRAMING  3
`define SSR_ST_PARITY   4
`define SSR_ST_TXDONE   5

// Character and serial clock figures.
`define SSR_LAST_BIT    3'h7
`define SSR_SCLK_HALF_NS 60
`define SSR_CLK_NS      5
`define SSR_ZERO8       8'h00

// Interrupt code for the highest pending request.
`define SSR_PRI_NONE    3'h0
`define SSR_PRI_FAULT   3'h1
`define SSR_PRI_RXFULL  3'h2
`define SSR_PRI_TXEMPTY 3'h3
`define SSR_PRI_TXDONE  3'h4

`endif

// [ssr_serial_unit.v]
// Clocked synchronous serial unit: shared transmit/receive engine, status
// flags, four interrupt request levels and transfer controller handshakes.
// Assumes one system clock, a simple strobe register port and an outside
// interrupt controller that arbitrates channels.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.vh"

module ssr_serial_unit
(
  // System clock and reset.
  input  wire       mclk,
  input  wire       rst_n,
  // Register port.
  input  wire [1:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output wire [7:0] regRdData,
  // Transfer controller port.
  input  wire       xferRxRead,
  output wire [7:0] xferRxData,
  input  wire       xferTxWrite,
  input  wire [7:0] xferTxData,
  output wire       xferRxReq,
  output wire       xferTxReq,
  // Serial link pins.
  input  wire       sclkIn,
  output wire       sclkOut,
  output wire       sclkOe,
  input  wire       rxd,
  output wire       txd,
  // Interrupt requests.
  output wire       rxFullIrq,
  output wire       txEmptyIrq,
  output wire       rxFaultIrq,
  output wire       txDoneIrq,
  output wire [2:0] irqTop
);

  localparam integer SCLK_HALF_I = (`SSR_SCLK_HALF_NS + `SSR_CLK_NS - 1) / `SSR_CLK_NS;
  localparam [7:0]   SCLK_HALF   = SCLK_HALF_I[7:0];

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg  [5:0] ctrl_ff;
  reg        txEmpty_ff;
  reg        rxFull_ff;
  reg        overrun_ff;
  reg        framing_ff;
  reg        parity_ff;
  reg        txDone_ff;
  reg  [7:0] rxShift_ff;
  reg  [7:0] rxBuf_ff;
  reg  [7:0] txBuf_ff;
  reg  [7:0] txShift_ff;
  reg        txd_ff;
  reg  [2:0] bitCnt_ff;
  reg        state_ff;
  reg        txMode_ff;
  reg  [7:0] rdData_ff;
  reg        sclkGen_ff;
  reg  [7:0] divCnt_ff;
  reg        sclkMeta_ff;
  reg        sclkSync_ff;
  reg        sclkLast_ff;
  reg        rxdMeta_ff;
  reg        rxdSync_ff;

  reg  [7:0] nxt_rxShift;
  reg  [7:0] nxt_rxBuf;
  reg  [7:0] nxt_txShift;
  reg        nxt_txd;
  reg  [2:0] nxt_bitCnt;
  reg        nxt_state;
  reg        nxt_txMode;
  reg        nxt_txEmpty;
  reg        nxt_rxFull;
  reg        nxt_overrun;
  reg        nxt_txDone;
  reg        hwSetFull;
  reg        hwSetOvr;
  reg        hwSetEmpty;
  reg        hwSetDone;

  wire txOn     = ctrl_ff[`SSR_CTRL_TXON];
  wire rxOn     = ctrl_ff[`SSR_CTRL_RXON];
  wire clkInt   = ctrl_ff[`SSR_CTRL_CLKINT];
  wire errAny   = overrun_ff | framing_ff | parity_ff;
  wire wrCtrl   = regWr && (regAddr == `SSR_ADDR_CTRL);
  wire wrStatus = regWr && (regAddr == `SSR_ADDR_STATUS);
  wire wrTxBuf  = regWr && (regAddr == `SSR_ADDR_TXBUF);

  // Serial clock and data input synchronisers.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sclkMeta_ff <= 1'b1;
      sclkSync_ff <= 1'b1;
      sclkLast_ff <= 1'b1;
      rxdMeta_ff  <= 1'b1;
      rxdSync_ff  <= 1'b1;
    end
    else
    begin
      sclkMeta_ff <= sclkIn;
      sclkSync_ff <= sclkMeta_ff;
      sclkLast_ff <= sclkSync_ff;
      rxdMeta_ff  <= rxd;
      rxdSync_ff  <= rxdMeta_ff;
    end
  end

  // Internal clock generator; the line idles high between characters.
  wire halfTick = (divCnt_ff == SCLK_HALF - 8'h01);

  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      divCnt_ff  <= `SSR_ZERO8;
      sclkGen_ff <= 1'b1;
    end
    else if (!clkInt || state_ff == ST_IDLE)
    begin
      divCnt_ff  <= `SSR_ZERO8;
      sclkGen_ff <= 1'b1;
    end
    else if (halfTick)
    begin
      divCnt_ff  <= `SSR_ZERO8;
      sclkGen_ff <= ~sclkGen_ff;
    end
    else
    begin
      divCnt_ff <= divCnt_ff + 8'h01;
    end
  end

  wire extRise = !clkInt && sclkSync_ff && !sclkLast_ff;
  wire extFall = !clkInt && !sclkSync_ff && sclkLast_ff;
  wire intRise = clkInt && state_ff == ST_BUSY && halfTick && !sclkGen_ff;
  wire intFall = clkInt && state_ff == ST_BUSY && halfTick && sclkGen_ff;
  wire sRise   = (extRise || intRise) && state_ff == ST_BUSY;
  wire sFall   = (extFall || intFall) && state_ff == ST_BUSY;

  wire canTx   = txOn && !txEmpty_ff;
  wire canRx   = rxOn && !txOn;
  wire aborted = txMode_ff ? !txOn : !rxOn;

  // Shared transfer engine; transmit and receive run on one clock.
  always @*
  begin
    nxt_rxShift = rxShift_ff;
    nxt_rxBuf   = rxBuf_ff;
    nxt_txShift = txShift_ff;
    nxt_txd     = txd_ff;
    nxt_bitCnt  = bitCnt_ff;
    nxt_state   = state_ff;
    nxt_txMode  = txMode_ff;
    hwSetFull   = 1'b0;
    hwSetOvr    = 1'b0;
    hwSetEmpty  = 1'b0;
    hwSetDone   = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (!errAny && (canTx || canRx))
        begin
          nxt_state  = ST_BUSY;
          nxt_bitCnt = 3'h0;
          nxt_txMode = txOn;
          if (canTx)
          begin
            nxt_txShift = txBuf_ff;
            hwSetEmpty  = 1'b1;
          end
        end
      end
      ST_BUSY:
      begin
        if (aborted)
        begin
          nxt_state = ST_IDLE;
        end
        else
        begin
          if (sFall && txMode_ff)
          begin
            nxt_txd     = txShift_ff[0];
            nxt_txShift = {1'b0, txShift_ff[7:1]};
          end
          if (sRise)
          begin
            nxt_rxShift = {rxdSync_ff, rxShift_ff[7:1]};
            nxt_bitCnt  = bitCnt_ff + 3'h1;
            if (bitCnt_ff == `SSR_LAST_BIT)
            begin
              if (rxOn)
              begin
                if (!rxFull_ff)
                begin
                  nxt_rxBuf = nxt_rxShift;
                  hwSetFull = 1'b1;
                end
                else
                begin
                  hwSetOvr = 1'b1;
                end
              end
              if (txMode_ff)
              begin
                if (!txEmpty_ff && !hwSetOvr)
                begin
                  nxt_txShift = txBuf_ff;
                  hwSetEmpty  = 1'b1;
                end
                else
                begin
                  hwSetDone = 1'b1;
                  nxt_state = ST_IDLE;
                end
              end
              else if (hwSetOvr || !rxOn)
              begin
                nxt_state = ST_IDLE;
              end
            end
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Status flags; a hardware set wins over a clear in the same cycle.
  wire swClrEmpty = (wrStatus && !regWrData[`SSR_ST_TXEMPTY]) || xferTxWrite;
  wire swClrFull  = (wrStatus && !regWrData[`SSR_ST_RXFULL]) || xferRxRead;
  wire swClrOvr   = wrStatus && !regWrData[`SSR_ST_OVERRUN];
  wire txOff      = wrCtrl && !regWrData[`SSR_CTRL_TXON];

  always @*
  begin
    nxt_txEmpty = txEmpty_ff;
    nxt_txDone  = txDone_ff;
    if (swClrEmpty)
    begin
      nxt_txEmpty = 1'b0;
      nxt_txDone  = 1'b0;
    end
    if (hwSetEmpty || txOff)
    begin
      nxt_txEmpty = 1'b1;
    end
    if (hwSetDone || txOff)
    begin
      nxt_txDone = 1'b1;
    end
    nxt_rxFull = (rxFull_ff && !swClrFull) || hwSetFull;
    nxt_overrun = (overrun_ff && !swClrOvr) || hwSetOvr;
  end

  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_ff    <= `SSR_CTRL_RST;
      txEmpty_ff <= 1'b1;
      rxFull_ff  <= 1'b0;
      overrun_ff <= 1'b0;
      framing_ff <= 1'b0;
      parity_ff  <= 1'b0;
      txDone_ff  <= 1'b1;
      rxShift_ff <= `SSR_ZERO8;
      rxBuf_ff   <= `SSR_ZERO8;
      txBuf_ff   <= `SSR_ZERO8;
      txShift_ff <= `SSR_ZERO8;
      txd_ff     <= 1'b1;
      bitCnt_ff  <= 3'h0;
      state_ff   <= ST_IDLE;
      txMode_ff  <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
      begin
        ctrl_ff <= regWrData[5:0];
      end
      if (wrTxBuf)
      begin
        txBuf_ff <= regWrData;
      end
      else if (xferTxWrite)
      begin
        txBuf_ff <= xferTxData;
      end
      if (wrStatus && !regWrData[`SSR_ST_FRAMING])
      begin
        framing_ff <= 1'b0;
      end
      if (wrStatus && !regWrData[`SSR_ST_PARITY])
      begin
        parity_ff <= 1'b0;
      end
      txEmpty_ff <= nxt_txEmpty;
      txDone_ff  <= nxt_txDone;
      rxFull_ff  <= nxt_rxFull;
      overrun_ff <= nxt_overrun;
      rxShift_ff <= nxt_rxShift;
      rxBuf_ff   <= nxt_rxBuf;
      txShift_ff <= txOff ? `SSR_ZERO8 : nxt_txShift;
      txd_ff     <= nxt_txd;
      bitCnt_ff  <= nxt_bitCnt;
      state_ff   <= nxt_state;
      txMode_ff  <= nxt_txMode;
    end
  end

  // Register read data, valid the cycle after the read strobe.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rdData_ff <= `SSR_ZERO8;
    end
    else if (regRd)
    begin
      case (regAddr)
        `SSR_ADDR_CTRL:   rdData_ff <= {2'b00, ctrl_ff};
        `SSR_ADDR_STATUS: rdData_ff <= {2'b00, txDone_ff, parity_ff, framing_ff,
                                        overrun_ff, rxFull_ff, txEmpty_ff};
        `SSR_ADDR_RXBUF:  rdData_ff <= rxBuf_ff;
        `SSR_ADDR_TXBUF:  rdData_ff <= txBuf_ff;
        default:          rdData_ff <= `SSR_ZERO8;
      endcase
    end
    else
    begin
      rdData_ff <= `SSR_ZERO8;
    end
  end

  // Interrupt request levels, one line each.
  assign rxFullIrq  = rxFull_ff && ctrl_ff[`SSR_CTRL_RX_IEN];
  assign rxFaultIrq = errAny && ctrl_ff[`SSR_CTRL_RX_IEN];
  assign txEmptyIrq = txEmpty_ff && ctrl_ff[`SSR_CTRL_EMPTY_IEN];
  assign txDoneIrq  = txDone_ff && ctrl_ff[`SSR_CTRL_DONE_IEN];

  // Only the data requests may start the transfer controller.
  assign xferRxReq = rxFullIrq;
  assign xferTxReq = txEmptyIrq;

  assign irqTop = rxFaultIrq ? `SSR_PRI_FAULT :
                  rxFullIrq  ? `SSR_PRI_RXFULL :
                  txEmptyIrq ? `SSR_PRI_TXEMPTY :
                  txDoneIrq  ? `SSR_PRI_TXDONE : `SSR_PRI_NONE;

  assign regRdData  = rdData_ff;
  assign xferRxData = rxBuf_ff;
  assign txd        = txd_ff;
  assign sclkOut    = sclkGen_ff;
  assign sclkOe     = clkInt;

endmodule // ssr_serial_unit
`default_nettype wire

// [ssr_serial_unit_chk.sv]
// Port checker for ssr_serial_unit: request levels, priority and services.
// Assumes only the unit's ports; bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.vh"
module ssr_serial_unit_chk
(
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       rst_n,
  // Register port.
  input wire logic [1:0] regAddr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  // Transfer controller port.
  input wire logic       xferRxRead,
  input wire logic       xferTxWrite,
  input wire logic       xferRxReq,
  input wire logic       xferTxReq,
  // Link pins and requests.
  input wire logic       sclkIn,
  input wire logic       sclkOe,
  input wire logic       txd,
  input wire logic       rxFullIrq,
  input wire logic       txEmptyIrq,
  input wire logic       rxFaultIrq,
  input wire logic       txDoneIrq,
  input wire logic [2:0] irqTop
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence sStRd;
    regRd && regAddr == `SSR_ADDR_STATUS;
  endsequence
  sequence sTxSvc;
    xferTxWrite && txEmptyIrq;
  endsequence
  a_rx_xfer_req: assert property (xferRxReq == rxFullIrq)
    else $error("rx transfer request differs from rx full request");
  a_tx_xfer_req: assert property (xferTxReq == txEmptyIrq)
    else $error("tx transfer request differs from tx empty request");
  a_pri_order: assert property (irqTop == (rxFaultIrq ? `SSR_PRI_FAULT :
    rxFullIrq ? `SSR_PRI_RXFULL : txEmptyIrq ? `SSR_PRI_TXEMPTY :
    txDoneIrq ? `SSR_PRI_TXDONE : `SSR_PRI_NONE))
    else $error("top request code out of order");
  a_rx_svc_clr: assert property (xferRxRead && rxFullIrq |=> !rxFullIrq)
    else $error("controller read left rx full set");
  a_tx_svc_clr: assert property (sTxSvc |=> !txEmptyIrq && !txDoneIrq)
    else $error("controller write left tx empty or done set");
  a_full_flag_rd: assert property (sStRd ##0 rxFullIrq |=> regRdData[1])
    else $error("rx full request without its flag");
  a_fault_flag_rd: assert property (sStRd ##0 rxFaultIrq |=> |regRdData[4:2])
    else $error("fault request without an error flag");
  a_empty_flag_rd: assert property (sStRd ##0 txEmptyIrq |=> regRdData[0])
    else $error("tx empty request without its flag");
  a_done_flag_rd: assert property (sStRd ##0 txDoneIrq |=> regRdData[5])
    else $error("tx done request without its flag");
  a_txd_after_fall: assert property ($changed(txd) && !sclkOe |-> !sclkIn)
    else $error("txd moved while the outside clock was high");
endmodule // ssr_serial_unit_chk
bind ssr_serial_unit ssr_serial_unit_chk i_ssr_serial_unit_chk (.mclk, .rst_n, .regAddr,
  .regRd, .regRdData, .xferRxRead, .xferTxWrite, .xferRxReq, .xferTxReq, .sclkIn,
  .sclkOe, .txd, .rxFullIrq, .txEmptyIrq, .rxFaultIrq, .txDoneIrq, .irqTop);
`default_nettype wire

// [ssr_link_partner.sv]
// Remote synchronous partner: clocks the link from outside, drives rxd.
// Assumes the unit takes its serial clock from outside; clock idles high.
`timescale 1ns/1ps
`default_nettype none
module ssr_link_partner
(
  // Link lines.
  output logic       sclk,
  output logic       rxd,
  input  wire logic  txd,
  // Byte last seen on txd.
  output logic [7:0] seen
);
  integer i;
  initial
  begin
    sclk = 1'b1;
    rxd  = 1'b1;
    seen = 8'h00;
  end
  // Data moves at the fall and is taken at the rise, 125 ns a bit.
  task frame(input logic [7:0] b);
    for (i = 0; i < 8; i = i + 1)
    begin
      sclk = 1'b0;
      rxd = b[i];
      #62.5;
      sclk = 1'b1;
      seen[i] = txd;
      #62.5;
    end
    // The released data line flips so a stale bit cannot pass as data.
    rxd = ~rxd;
  endtask
endmodule // ssr_link_partner
`default_nettype wire

// [ssr_serial_unit_tb_top.sv]
// Self-checking bench for ssr_serial_unit with an outside-clocked partner.
// Assumes the constants header; system clock 200 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.vh"
module ssr_serial_unit_tb_top;
  logic       mclk, rst_n, regWr, regRd, xferRxRead, xferTxWrite, pc;
  logic [1:0] regAddr;
  logic [7:0] regWrData, xferTxData, rdv, b, t, cap;
  wire  [7:0] regRdData, xferRxData, seen;
  wire        xferRxReq, xferTxReq, sclk, sclkOut, sclkOe, rxd, txd;
  wire        rxFullIrq, txEmptyIrq, rxFaultIrq, txDoneIrq;
  wire  [2:0] irqTop;
  integer     failures, checks_done, seed, k, n;
  ssr_serial_unit i_ssr_serial_unit (.mclk, .rst_n, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .xferRxRead, .xferRxData, .xferTxWrite, .xferTxData,
    .xferRxReq, .xferTxReq, .sclkIn(sclk), .sclkOut, .sclkOe, .rxd, .txd,
    .rxFullIrq, .txEmptyIrq, .rxFaultIrq, .txDoneIrq, .irqTop);
  ssr_link_partner i_ssr_link_partner (.sclk, .rxd, .txd, .seen);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task step(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    step(1);
    regWr <= 1'b0;
    // One idle cycle, so a following call never drives the strobe twice at once.
    step(1);
  endtask
  task rd(input logic [1:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    step(1);
    regRd <= 1'b0;
    rdv = regRdData;
    step(1);
  endtask
  task rxsvc;
    xferRxRead <= 1'b1;
    step(1);
    xferRxRead <= 1'b0;
    step(1);
  endtask
  task link(input logic [7:0] d);
    i_ssr_link_partner.frame(d);
    step(12);
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #80000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial
  begin
    {rst_n, regWr, regRd, xferRxRead, xferTxWrite, regAddr} = 0;
    {regWrData, xferTxData} = 0;
    {failures, checks_done} = 0;
    seed = 74;
    step(8);
    rst_n <= 1'b1;
    step(3);
    rd(`SSR_ADDR_STATUS);
    chk("status", 8'h21, rdv);
    chk("irqs", 8'h00, {irqTop, sclkOe, rxFullIrq, txEmptyIrq, rxFaultIrq, txDoneIrq});
    chk("pins", 8'h03, {6'h00, txd, sclkOut});
    $display("test reset done");
    wr(`SSR_ADDR_CTRL, 8'h0A);
    for (k = 0; k < 3; k = k + 1)
    begin
      b = (k == 2) ? 8'h80 : 8'($random(seed));
      link(b);
      chk("xferRxData", b, xferRxData);
      chk("rx reqs", 8'h03, {6'h00, rxFullIrq, xferRxReq});
      chk("irqTop", 8'h02, {5'h00, irqTop});
      rxsvc;
      chk("rx full", 8'h00, {7'h00, rxFullIrq});
    end
    $display("test receive done");
    b = 8'($random(seed));
    link(b);
    link(~b);
    rd(`SSR_ADDR_STATUS);
    chk("status", 8'h27, rdv);
    chk("rx buf", b, xferRxData);
    chk("irqTop", 8'h01, {5'h00, irqTop});
    rxsvc;
    link(8'h5A);
    chk("stopped", {b[7:1], 1'b0}, {xferRxData[7:1], rxFullIrq});
    wr(`SSR_ADDR_CTRL, 8'h02);
    chk("masked", 8'h00, {7'h00, rxFaultIrq});
    wr(`SSR_ADDR_STATUS, 8'h00);
    wr(`SSR_ADDR_CTRL, 8'h0A);
    chk("cleared", 8'h00, {7'h00, rxFaultIrq});
    link(8'hC3);
    chk("resumed", 8'hC3, xferRxData);
    rxsvc;
    $display("test overrun done");
    wr(`SSR_ADDR_CTRL, 8'h00);
    wr(`SSR_ADDR_CTRL, 8'h1F);
    rd(`SSR_ADDR_STATUS);
    chk("status", 8'h21, rdv);
    chk("tx reqs", 8'h07, {5'h00, txEmptyIrq, txDoneIrq, xferTxReq});
    chk("irqTop", 8'h03, {5'h00, irqTop});
    for (k = 0; k < 2; k = k + 1)
    begin
      t = 8'($random(seed));
      b = 8'($random(seed));
      xferTxData <= t;
      xferTxWrite <= 1'b1;
      step(1);
      xferTxWrite <= 1'b0;
      chk("tx svc", 8'h00, {6'h00, txEmptyIrq, txDoneIrq});
      step(10);
      link(b);
      chk("seen", t, seen);
      chk("rx data", b, xferRxData);
      chk("tx end", 8'h03, {6'h00, txEmptyIrq, txDoneIrq});
      rxsvc;
    end
    // Back to back characters: the next byte is written while the first is on the line.
    t = 8'($random(seed));
    b = 8'($random(seed));
    xferTxData <= t;
    xferTxWrite <= 1'b1;
    step(1);
    xferTxWrite <= 1'b0;
    step(10);
    fork
      link(b);
      begin
        step(40);
        xferTxData <= ~t;
        xferTxWrite <= 1'b1;
        step(1);
        xferTxWrite <= 1'b0;
      end
    join
    chk("seen first", t, seen);
    chk("rx first", b, xferRxData);
    chk("no done", 8'h02, {6'h00, txEmptyIrq, txDoneIrq});
    rxsvc;
    link(~b);
    chk("seen second", ~t, seen);
    chk("rx second", ~b, xferRxData);
    chk("tx end", 8'h03, {6'h00, txEmptyIrq, txDoneIrq});
    rxsvc;
    $display("test duplex done");
    // Transmit only on the unit's own clock; the bench follows the driven clock pin.
    wr(`SSR_ADDR_CTRL, 8'h00);
    wr(`SSR_ADDR_CTRL, 8'h31);
    t = 8'($random(seed));
    wr(`SSR_ADDR_TXBUF, t);
    wr(`SSR_ADDR_STATUS, 8'h3E);
    pc = 1'b1;
    n = 0;
    repeat (260)
    begin
      step(1);
      if (sclkOut && !pc)
      begin
        cap = {txd, cap[7:1]};
        n = n + 1;
      end
      pc = sclkOut;
    end
    chk("clock pulses", 8'h08, 8'(n));
    chk("clock out data", t, cap);
    chk("clock out end", 8'h07, {5'h00, sclkOe, sclkOut, txDoneIrq});
    $display("test clock out done");
    tally_and_finish;
  end
endmodule // ssr_serial_unit_tb_top
`default_nettype wire
